// ---- rtl/sfria_defines.vh ----
// Constants for the switch fabric reset and interrupt aggregator.
// Included by the design file; definitions only.
`ifndef SFRIA_DEFINES_VH
`define SFRIA_DEFINES_VH

`define SFRIA_AW               12
`define SFRIA_DW               32
`define SFRIA_ADDR_RESET       12'h001
`define SFRIA_ADDR_MASK        12'h004
`define SFRIA_ADDR_PEND        12'h005
`define SFRIA_ADDR_P0_VER      12'h400
`define SFRIA_ADDR_P1_VER      12'h800
`define SFRIA_ADDR_P2_VER      12'hC00
`define SFRIA_ADDR_SYS_STS     12'h010
`define SFRIA_ADDR_SYS_MASK    12'h011
`define SFRIA_NSRC             7
`define SFRIA_NRSV             2
`define SFRIA_NPORT            3
`define SFRIA_MASK_W           9
`define SFRIA_VER_W            12
`define SFRIA_BIT_RESET        0
`define SFRIA_BIT_BM           6
`define SFRIA_BIT_SWE          5
`define SFRIA_BIT_P2           2
`define SFRIA_BIT_P1           1
`define SFRIA_BIT_P0           0
`define SFRIA_MASK_RST         7'h7F
`define SFRIA_MASK_WMASK       9'h1FF
`define SFRIA_PEND_VALID       7'h67
`define SFRIA_SYS_BIT_FABRIC   0
`define SFRIA_ZERO32           32'h00000000

`endif

// ---- rtl/sfria_top.v ----
// Switch fabric global control: fabric reset bit, global interrupt mask and
// pending aggregation, port MAC version registers, system interrupt summary.
// Assumes a single-cycle register port and level pending inputs from sub-units.
//
// Summary of operation
// - Reset bit one holds fabric in reset
// - Mask bit set blocks its source
// - Unmasked pending sets fabric summary bit
// - Pending bits update regardless of mask
// - Mask layout bits 6,5,2,1,0, reset masked
// - Pending bit 6 from buffer manager
// - Pending bit 5 from switch engine
// - Pending bits 2..0 from port MACs
// - Pending cleared on read, reset zero
// - Three ports share identical version layout
// - Read-only version registers per port MAC
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "sfria_defines.vh"

module sfria_top #(
  parameter [3:0] DEVICE_TYPE  = 4'h1, // Arbitrary value
  parameter [3:0] CHIP_VERSION = 4'h1, // Arbitrary value
  parameter [3:0] REVISION     = 4'h1  // Arbitrary value
) (
  // Clock and reset
  input  wire                     clock,
  input  wire                     nrst,
  // Register port
  input  wire [`SFRIA_AW-1:0]     addr,
  input  wire [`SFRIA_DW-1:0]     wdata,
  input  wire                     wr,
  input  wire                     rd,
  output reg  [`SFRIA_DW-1:0]     rdata,
  // Sub-unit pending requests (any unmasked flag of each unit)
  input  wire                     buffer_mgr_source,
  input  wire                     switch_engine_source,
  input  wire                     port2_mac_source,
  input  wire                     port1_mac_source,
  input  wire                     port0_mac_source,
  // Fabric outputs
  output wire                     fabric_reset_bit,
  output wire                     fabric_summary,
  output wire                     irq
);

  // Fabric reset bit
  reg                       reset_r;
  reg                       reset_nxt;

  // System interrupt status and mask
  reg                       sys_sts_r;
  reg                       sys_sts_nxt;
  reg                       sys_mask_r;
  reg                       sys_mask_nxt;

  // Read path
  reg  [`SFRIA_DW-1:0]      rdata_nxt;
  reg  [`SFRIA_DW-1:0]      ver_rd;
  integer                   k;

  // Address decode
  wire                      hit_reset;
  wire                      hit_mask;
  wire                      hit_pend;
  wire                      hit_sys_sts;
  wire                      hit_sys_mask;
  wire [`SFRIA_NPORT-1:0]   hit_ver;

  // Write and read strobes
  wire                      wr_reset;
  wire                      wr_mask;
  wire                      wr_sys_sts;
  wire                      wr_sys_mask;
  wire                      rd_pend;
  wire                      sys_clr;
  wire                      sys_set;

  // Mask register and named mask bits
  wire [`SFRIA_MASK_W-1:0]  mask_w;
  wire                      mask_bm;
  wire                      mask_swe;
  wire                      mask_p2;
  wire                      mask_p1;
  wire                      mask_p0;
  wire [`SFRIA_NSRC-1:0]    mask_gate;

  // Pending and summary
  wire [`SFRIA_NSRC-1:0]    src;
  wire [`SFRIA_NSRC-1:0]    pend_w;
  wire [`SFRIA_NSRC-1:0]    unmasked;
  wire                      summary;

  // Version fields and per-port read words
  wire [3:0]                ver_type;
  wire [3:0]                ver_chip;
  wire [3:0]                ver_rev;
  wire [`SFRIA_VER_W-1:0]   ver_word;
  wire [`SFRIA_NPORT*`SFRIA_AW-1:0] ver_addr_tbl;
  wire [`SFRIA_NPORT*`SFRIA_DW-1:0] ver_rd_bus;

  // Read words with reserved bits zero, except mask reserved bits read as stored
  wire [`SFRIA_DW-1:0]      rd_mask_word;
  wire [`SFRIA_DW-1:0]      rd_pend_word;
  wire [`SFRIA_DW-1:0]      rd_sts_word;
  wire [`SFRIA_DW-1:0]      rd_smask_word;

  // Constant views of the defines
  localparam [`SFRIA_NSRC-1:0]   PEND_VALID = `SFRIA_PEND_VALID;
  localparam [`SFRIA_MASK_W-1:0] MASK_RST   = `SFRIA_MASK_WMASK;

  // Address decode
  assign hit_reset    = (addr == `SFRIA_ADDR_RESET);
  assign hit_mask     = (addr == `SFRIA_ADDR_MASK);
  assign hit_pend     = (addr == `SFRIA_ADDR_PEND);
  assign hit_sys_sts  = (addr == `SFRIA_ADDR_SYS_STS);
  assign hit_sys_mask = (addr == `SFRIA_ADDR_SYS_MASK);

  // Strobes qualified by address
  assign wr_reset     = wr & hit_reset;
  assign wr_mask      = wr & hit_mask;
  assign wr_sys_sts   = wr & hit_sys_sts;
  assign wr_sys_mask  = wr & hit_sys_mask;
  assign rd_pend      = rd & hit_pend;
  assign sys_clr      = wr_sys_sts & wdata[`SFRIA_SYS_BIT_FABRIC];

  // Mask layout, one bit per source
  assign mask_bm   = mask_w[`SFRIA_BIT_BM];
  assign mask_swe  = mask_w[`SFRIA_BIT_SWE];
  assign mask_p2   = mask_w[`SFRIA_BIT_P2];
  assign mask_p1   = mask_w[`SFRIA_BIT_P1];
  assign mask_p0   = mask_w[`SFRIA_BIT_P0];
  assign mask_gate = {mask_bm, mask_swe, {`SFRIA_NRSV{1'b1}}, mask_p2, mask_p1, mask_p0};

  // Sources in pending-register order
  assign src = {buffer_mgr_source, switch_engine_source, {`SFRIA_NRSV{1'b0}},
                port2_mac_source, port1_mac_source, port0_mac_source};

  // Reset bit is level, held until software writes zero
  always @* begin
    reset_nxt = reset_r;
    if (wr_reset) begin
      reset_nxt = wdata[`SFRIA_BIT_RESET];
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reset_r <= 1'b0;
    end else begin
      reset_r <= reset_nxt;
    end
  end
  assign fabric_reset_bit = reset_r;

  // Mask register, one flop per bit
  // Reserved pairs stored as written; software keeps them ones
  genvar b;
  generate
    for (b = 0; b < `SFRIA_MASK_W; b = b + 1) begin : g_mask
      reg bit_r;
      reg bit_nxt;

      always @* begin
        bit_nxt = bit_r;
        if (wr_mask) begin
          bit_nxt = wdata[b];
        end
      end

      always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          bit_r <= MASK_RST[b];
        end else begin
          bit_r <= bit_nxt;
        end
      end

      assign mask_w[b] = bit_r;
    end
  endgenerate

  // One sticky flag per source, set wins over clear-on-read
  genvar s;
  generate
    for (s = 0; s < `SFRIA_NSRC; s = s + 1) begin : g_pend
      if (PEND_VALID[s]) begin : g_used
        reg  flag_r;
        reg  flag_nxt;
        wire set_evt;
        wire clr_evt;

        assign set_evt = src[s];
        assign clr_evt = rd_pend;

        // A source still high during the read keeps its flag
        always @* begin
          flag_nxt = flag_r;
          if (clr_evt) begin
            flag_nxt = 1'b0;
          end
          if (set_evt) begin
            flag_nxt = 1'b1;
          end
        end

        always @(posedge clock or negedge nrst) begin
          if (!nrst) begin
            flag_r <= 1'b0;
          end else begin
            flag_r <= flag_nxt;
          end
        end

        assign pend_w[s]   = flag_r;
        assign unmasked[s] = flag_r & ~mask_gate[s];
      end else begin : g_rsv
        // Reserved positions never pend
        assign pend_w[s]   = 1'b0;
        assign unmasked[s] = 1'b0;
      end
    end
  endgenerate

  // Summary follows OR of unmasked pending flags
  assign summary        = |unmasked;
  assign fabric_summary = summary;
  assign sys_set        = summary;

  // System status sticky bit, write one to clear
  always @* begin
    sys_sts_nxt = sys_sts_r;
    if (sys_set) begin
      sys_sts_nxt = 1'b1;
    end else if (sys_clr) begin
      sys_sts_nxt = 1'b0;
    end
  end

  // System mask bit enables the interrupt output
  always @* begin
    sys_mask_nxt = sys_mask_r;
    if (wr_sys_mask) begin
      sys_mask_nxt = wdata[`SFRIA_SYS_BIT_FABRIC];
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_sts_r <= 1'b0;
    end else begin
      sys_sts_r <= sys_sts_nxt;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_mask_r <= 1'b0;
    end else begin
      sys_mask_r <= sys_mask_nxt;
    end
  end
  assign irq = sys_sts_r & sys_mask_r;

  // Same version word behind every port
  assign ver_type = DEVICE_TYPE;
  assign ver_chip = CHIP_VERSION;
  assign ver_rev  = REVISION;
  assign ver_word = {ver_type, ver_chip, ver_rev};

  // Register numbers of the three version registers
  assign ver_addr_tbl = {`SFRIA_ADDR_P2_VER, `SFRIA_ADDR_P1_VER, `SFRIA_ADDR_P0_VER};

  genvar p;
  generate
    for (p = 0; p < `SFRIA_NPORT; p = p + 1) begin : g_ver
      wire [`SFRIA_VER_W-1:0] word;

      assign word       = ver_word;
      assign hit_ver[p] = (addr == ver_addr_tbl[p*`SFRIA_AW +: `SFRIA_AW]);
      assign ver_rd_bus[p*`SFRIA_DW +: `SFRIA_DW] =
        hit_ver[p] ? {{(`SFRIA_DW-`SFRIA_VER_W){1'b0}}, word} : `SFRIA_ZERO32;
    end
  endgenerate

  // Merge per-port words
  always @* begin
    ver_rd = `SFRIA_ZERO32;
    for (k = 0; k < `SFRIA_NPORT; k = k + 1) begin
      ver_rd = ver_rd | ver_rd_bus[k*`SFRIA_DW +: `SFRIA_DW];
    end
  end

  // Read words with reserved bits zero, except mask reserved bits read as stored
  assign rd_mask_word  = {{(`SFRIA_DW-`SFRIA_MASK_W){1'b0}}, mask_w};
  assign rd_pend_word  = {{(`SFRIA_DW-`SFRIA_NSRC){1'b0}}, pend_w};
  assign rd_sts_word   = {{(`SFRIA_DW-1){1'b0}}, sys_sts_r};
  assign rd_smask_word = {{(`SFRIA_DW-1){1'b0}}, sys_mask_r};

  // Read multiplexer; unmapped and write-only addresses read zero
  always @* begin
    rdata_nxt = `SFRIA_ZERO32;
    if (rd) begin
      case (addr)
        `SFRIA_ADDR_RESET: begin
          rdata_nxt = `SFRIA_ZERO32;
        end
        `SFRIA_ADDR_MASK: begin
          rdata_nxt = rd_mask_word;
        end
        `SFRIA_ADDR_PEND: begin
          rdata_nxt = rd_pend_word;
        end
        `SFRIA_ADDR_P0_VER: begin
          rdata_nxt = ver_rd;
        end
        `SFRIA_ADDR_P1_VER: begin
          rdata_nxt = ver_rd;
        end
        `SFRIA_ADDR_P2_VER: begin
          rdata_nxt = ver_rd;
        end
        `SFRIA_ADDR_SYS_STS: begin
          rdata_nxt = rd_sts_word;
        end
        `SFRIA_ADDR_SYS_MASK: begin
          rdata_nxt = rd_smask_word;
        end
        default: begin
          rdata_nxt = `SFRIA_ZERO32;
        end
      endcase
    end
  end

  // Read data stand one cycle, zero otherwise
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= `SFRIA_ZERO32;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule

// ---- tb/sfria_chk.sv ----
// Checker for the fabric aggregator top-level ports.
// Assumes it is bound to every sfria_top instance.
`timescale 1ns/1ps
module sfria_chk (
  input wire        clock, nrst, wr, rd, buffer_mgr_source, switch_engine_source,
  input wire        port2_mac_source, port1_mac_source, port0_mac_source,
  input wire        fabric_reset_bit, fabric_summary, irq,
  input wire [11:0] addr,
  input wire [31:0] wdata, rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire any_src = buffer_mgr_source | switch_engine_source | port2_mac_source
               | port1_mac_source | port0_mac_source;
  sequence s_pread; rd && addr == 12'h005; endsequence
  a_reset_set: assert property (wr && addr == 12'h001 |=> fabric_reset_bit == $past(wdata[0]))
    else $error("reset bit not written");
  a_reset_hold: assert property (!(wr && addr == 12'h001) |=> $stable(fabric_reset_bit))
    else $error("reset bit changed alone");
  a_rd_idle: assert property (!rd |=> rdata == 32'h0) else $error("rdata not idle");
  a_wo_zero: assert property (rd && addr == 12'h001 |=> rdata == 32'h0) else $error("reset read");
  a_ver_res: assert property (rd && addr[9:0] == 10'h0 && addr[11:10] != 2'h0
    |=> rdata[31:12] == 20'h0) else $error("version reserved bits");
  a_pend_res: assert property (s_pread |=> rdata[31:7] == 25'h0 && rdata[4:3] == 2'h0)
    else $error("pending reserved bits");
  a_bm_pend: assert property (buffer_mgr_source ##1 !rd ##1 s_pread |=> rdata[6])
    else $error("buffer manager flag lost");
  a_rd_clear: assert property (rd && addr == 12'h005 && !any_src |=> !fabric_summary)
    else $error("summary after read");
  a_mask_gate: assert property (wr && addr == 12'h004 && wdata[6:0] == 7'h7F |=> !fabric_summary)
    else $error("summary while masked");
endmodule
bind sfria_top sfria_chk i_sfria_chk (.clock, .nrst, .wr, .rd, .buffer_mgr_source,
  .switch_engine_source, .port2_mac_source, .port1_mac_source, .port0_mac_source,
  .fabric_reset_bit, .fabric_summary, .irq, .addr, .wdata, .rdata);

// ---- tb/tb_sfria_top.sv ----
// Bench for the fabric aggregator: register port tasks and source pulses.
// Assumes the design include path holds the design defines.
`timescale 1ns/1ps
module tb_sfria_top;
  reg         clock = 0, nrst = 0, wr = 0, rd = 0;
  reg  [11:0] addr  = 12'h000;
  reg  [31:0] wdata = 32'h0;
  reg  [4:0]  src   = 5'h0;
  wire [31:0] rdata;
  wire        rst_bit, sum, irq;
  integer     n_mismatch = 0, checked = 0, cyc = 0, i;
  sfria_top i_sfria_top (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .buffer_mgr_source(src[4]), .switch_engine_source(src[3]),
    .port2_mac_source(src[2]), .port1_mac_source(src[1]), .port0_mac_source(src[0]),
    .fabric_reset_bit(rst_bit), .fabric_summary(sum), .irq(irq));
  initial forever #20 clock = ~clock;
  task chk(input [31:0] s, input [31:0] e); begin
    checked = checked + 1;
    if (s !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task wreg(input [11:0] a, input [31:0] d); begin
    @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock); wr <= 1'b0; #1;
  end endtask
  task rreg(input [11:0] a, input [31:0] e); begin
    @(posedge clock); addr <= a; rd <= 1'b1;
    @(posedge clock); rd <= 1'b0; #1 chk(rdata, e);
  end endtask
  task pulse(input integer k); begin
    @(posedge clock); src <= 5'h1 << k;
    @(posedge clock); src <= 5'h0; #1;
  end endtask
  task results; begin
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin n_mismatch = n_mismatch + 1; results; end
  end
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    rreg(12'h004, 32'h1FF);
    rreg(12'h005, 32'h0);
    for (i = 1; i < 4; i = i + 1) rreg(i << 10, 32'h111);
    rreg(12'h001, 32'h0);
    rreg(12'h7FF, 32'h0);
    wreg(12'h001, 32'h1); chk(rst_bit, 32'h1);
    wreg(12'h001, 32'h0); chk(rst_bit, 32'h0);
    wreg(12'h004, 32'h198);
    wreg(12'h011, 32'h1);
    for (i = 0; i < 5; i = i + 1) begin
      pulse(i); chk(sum, 32'h1);
      repeat (2) @(posedge clock); #1 chk(irq, 32'h1);
      rreg(12'h005, (i > 2) ? 32'h1 << (i + 2) : 32'h1 << i);
      chk(sum, 32'h0);
      wreg(12'h010, 32'h1); chk(irq, 32'h0);
    end
    wreg(12'h004, 32'h1FF);
    pulse(4); chk(sum, 32'h0);
    rreg(12'h005, 32'h40);
    results;
  end
endmodule
